// File: rtl/ppr_defines.vh
`ifndef PPR_DEFINES_VH
`define PPR_DEFINES_VH
// register offsets
`define PPR_OFF_DATA    3'h0
`define PPR_OFF_STATUS  3'h1
`define PPR_OFF_CONTROL 3'h2
`define PPR_OFF_ADDR    3'h3
`define PPR_OFF_DSTR_LO 3'h4
// control fields
`define PPR_CTL_DIR     5
`define PPR_CTL_IRQEN   4
`define PPR_CTL_SELIN   3
`define PPR_CTL_INIT    2
`define PPR_CTL_AUTOFD  1
`define PPR_CTL_STROBE  0
`define PPR_CTL_RESET   6'h00
`define PPR_CTL_WMASK   6'h3f
`define PPR_DATA_RESET  8'h00
// status fields
`define PPR_STAT_IRQ    2
// idle levels of busy, ack_n, paper_error, select, fault_n
`define PPR_SYNC_IDLE   5'h09
// modes
`define PPR_MODE_STD    3'h0
`define PPR_MODE_BIDIR  3'h1
`define PPR_MODE_EPP    3'h4
// port bases
`define PPR_BASE_A      10'h278
`define PPR_BASE_B      10'h378
`define PPR_BASE_C      10'h3bc
`endif

// File: rtl/ppr_sync.v
`timescale 1ns/1ps
// three-stage synchroniser; output moves once stages two and three agree
module ppr_sync #(
  parameter         W   = 5,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // clock and reset
  input  wire         mclk,
  input  wire         rst_n,
  // data
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  always @(posedge mclk) begin
    if (!rst_n) begin
      s1_q     <= RST;
      s2_q     <= RST;
      s3_q     <= RST;
      sync_out <= RST;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_out <= (s2_q & s3_q) | (sync_out & (s2_q | s3_q));
    end
  end
endmodule // ppr_sync

// File: rtl/ppr_port.v
// Overview of operation
// - control register at offset 2; bits 7:6 reserved, 5:0 reset to zero
// - standard mode: control bit 5 has no effect on the port
// - bidirectional mode: bit 5 zero drives data lines, one makes them inputs
// - bit 4 set: acknowledge assertion raises the host interrupt
// - control bit 3 one asserts select-in, zero negates it
// - control bit 2 one negates init, zero asserts it
// - control bit 1 one asserts auto-feed, zero negates it
// - control bit 0 one asserts strobe, zero negates it
// - epp decode: data 0, status 1, control 2, address 3, data strobe 4-7
// - epp only at bases 278h and 378h, never at 3bch
// - epp forward: data write stores and drives byte; resets to zero
// - epp reverse: data read returns live lines, stored byte unchanged
// - status bit 7 is inverted busy
// - status bit 6 zero while acknowledge asserted
// - status bit 5 one while paper error asserted
// - status bit 4 one while select asserted
// - status bit 3 zero while fault asserted
// - epp: status bit 2 reads one; bits 1:0 reserved
// - standard mode: data write drives byte onto data lines
// - mode 000 standard, 001 bidirectional
// - bidir with irq enabled: ack clears status bit 2; status read sets it
`timescale 1ns/1ps
`include "ppr_defines.vh"
module ppr_port (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // configuration
  input  wire [2:0]  port_mode,
  input  wire [9:0]  port_base,
  // host i/o port
  input  wire [2:0]  io_addr,
  input  wire        io_rd,
  input  wire        io_wr,
  input  wire [7:0]  io_wdata,
  output reg  [7:0]  io_rdata,
  // parallel data lines
  input  wire [7:0]  parallel_data_lines_in,
  output reg  [7:0]  parallel_data_lines_out,
  output reg         parallel_data_lines_oe,
  // control lines, active low
  output reg         strobe_n,
  output reg         autofeed_n,
  output reg         init_n,
  output reg         select_in_n,
  // peripheral status lines
  input  wire        busy,
  input  wire        ack_n,
  input  wire        paper_error,
  input  wire        select,
  input  wire        fault_n,
  // interrupt to host
  output reg         port_irq
);
  // register state and next values
  reg  [7:0] data_q;
  reg  [7:0] data_d;
  reg  [5:0] ctl_q;
  reg  [5:0] ctl_d;
  reg        irq_flag_q;
  reg        irq_flag_d;
  reg        ack_n_prev_q;
  reg  [7:0] epp_q;
  reg  [7:0] epp_d;
  reg        epp_sel_q;
  reg        epp_sel_d;

  // read path and pin next values
  reg  [7:0] rdata_d;
  reg  [7:0] stat_byte;
  reg  [7:0] pd_out_d;
  reg        pd_oe_d;
  reg        strobe_n_d;
  reg        autofeed_n_d;
  reg        init_n_d;
  reg        select_in_n_d;
  reg        port_irq_d;
  wire [4:0] stat_sync;

  // epp is only valid at two of the three bases
  function epp_ok;
    input [2:0] m;
    input [9:0] b;
    begin
      epp_ok = (m == `PPR_MODE_EPP) && ((b == `PPR_BASE_A) || (b == `PPR_BASE_B));
    end
  endfunction

  // one strobe at one offset; shared by the data, status and control decodes
  function hit;
    input       strobe;
    input [2:0] addr;
    input [2:0] offset;
    begin
      hit = strobe && (addr == offset);
    end
  endfunction

  // epp strobe window: address register plus the four data strobe offsets
  function in_strobe_window;
    input [2:0] addr;
    begin
      in_strobe_window = (addr >= `PPR_OFF_ADDR);
    end
  endfunction

  // mode decode; epp at the unsupported base falls back to standard
  wire is_epp   = epp_ok(port_mode, port_base);
  wire is_bidir = (port_mode == `PPR_MODE_BIDIR);
  wire is_std   = !is_epp && !is_bidir;
  // direction bit only meaningful outside standard mode
  wire reverse  = !is_std && ctl_q[`PPR_CTL_DIR];

  // sync order: busy, ack_n, paper_error, select, fault_n
  // reset to idle levels so no false acknowledge edge follows reset
  ppr_sync #(
    .W   (5),
    .RST (`PPR_SYNC_IDLE)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({busy, ack_n, paper_error, select, fault_n}),
    .sync_out (stat_sync)
  );

  wire s_busy  = stat_sync[4];
  wire s_ack_n = stat_sync[3];
  wire s_perr  = stat_sync[2];
  wire s_sel   = stat_sync[1];
  wire s_flt_n = stat_sync[0];

  // acknowledge edge and host strobe decode
  wire ack_fall = ack_n_prev_q && !s_ack_n;
  wire wr_data  = hit(io_wr, io_addr, `PPR_OFF_DATA);
  wire wr_ctl   = hit(io_wr, io_addr, `PPR_OFF_CONTROL);
  wire rd_data  = hit(io_rd, io_addr, `PPR_OFF_DATA);
  wire rd_stat  = hit(io_rd, io_addr, `PPR_OFF_STATUS);
  wire rd_ctl   = hit(io_rd, io_addr, `PPR_OFF_CONTROL);
  wire wr_strb  = is_epp && io_wr && in_strobe_window(io_addr);
  wire rd_strb  = is_epp && io_rd && in_strobe_window(io_addr);

  // writes in reverse are dropped; the stored byte survives a direction change
  always @* begin
    data_d = data_q;
    if (wr_data && !reverse) begin
      data_d = io_wdata;
    end
  end

  always @* begin
    ctl_d = ctl_q;
    if (wr_ctl) begin
      // bits 7:6 have no storage
      ctl_d = io_wdata[5:0] & `PPR_CTL_WMASK;
    end
  end

  always @* begin
    irq_flag_d = irq_flag_q;
    // ack event wins over the status read that sets the flag
    if (is_bidir && ctl_q[`PPR_CTL_IRQEN] && ack_fall) begin
      irq_flag_d = 1'b0;
    end else if (rd_stat) begin
      irq_flag_d = 1'b1;
    end
  end

  // a data register write hands the lines back to the stored byte
  always @* begin
    epp_d     = epp_q;
    epp_sel_d = epp_sel_q;
    if (wr_strb) begin
      epp_d     = io_wdata;
      epp_sel_d = 1'b1;
    end else if (wr_data && is_epp) begin
      epp_sel_d = 1'b0;
    end
  end

  // status shows synchronised lines only, never the raw pins
  always @* begin
    stat_byte    = 8'h00;
    stat_byte[7] = !s_busy;
    stat_byte[6] = s_ack_n;
    stat_byte[5] = s_perr;
    stat_byte[4] = s_sel;
    stat_byte[3] = s_flt_n;
    if (is_bidir) begin
      stat_byte[2] = irq_flag_q;
    end else begin
      stat_byte[2] = 1'b1;
    end
  end

  // offsets 3 to 7 read zero outside epp; control bits 7:6 read zero
  always @* begin
    rdata_d = io_rdata;
    if (rd_data) begin
      rdata_d = reverse ? parallel_data_lines_in : data_q;
    end else if (rd_stat) begin
      rdata_d = stat_byte;
    end else if (rd_ctl) begin
      rdata_d = {2'h0, ctl_q};
    end else if (rd_strb) begin
      rdata_d = parallel_data_lines_in;
    end else if (io_rd) begin
      rdata_d = 8'h00;
    end
  end

  // epp byte shows only while epp holds; a stale select must not leak into std
  always @* begin
    if (is_epp && epp_sel_q) begin
      pd_out_d = epp_q;
    end else begin
      pd_out_d = data_q;
    end
    if (reverse) begin
      pd_oe_d = 1'b0;
    end else begin
      pd_oe_d = 1'b1;
    end
  end

  // control pins are active low; init runs the other way round
  always @* begin
    if (ctl_q[`PPR_CTL_STROBE]) begin
      strobe_n_d = 1'b0;
    end else begin
      strobe_n_d = 1'b1;
    end
    if (ctl_q[`PPR_CTL_AUTOFD]) begin
      autofeed_n_d = 1'b0;
    end else begin
      autofeed_n_d = 1'b1;
    end
    if (ctl_q[`PPR_CTL_INIT]) begin
      init_n_d = 1'b1;
    end else begin
      init_n_d = 1'b0;
    end
    if (ctl_q[`PPR_CTL_SELIN]) begin
      select_in_n_d = 1'b0;
    end else begin
      select_in_n_d = 1'b1;
    end
  end

  // level interrupt: follows the synchronised acknowledge, no latch
  always @* begin
    port_irq_d = 1'b0;
    if (ctl_q[`PPR_CTL_IRQEN] && !s_ack_n) begin
      port_irq_d = 1'b1;
    end
  end

  // one flop per register; next values come from the blocks above
  always @(posedge mclk) begin
    if (!rst_n) begin
      data_q       <= `PPR_DATA_RESET;
      ctl_q        <= `PPR_CTL_RESET;
      irq_flag_q   <= 1'b1;
      ack_n_prev_q <= 1'b1;
      epp_q        <= 8'h00;
      epp_sel_q    <= 1'b0;
    end else begin
      data_q       <= data_d;
      ctl_q        <= ctl_d;
      irq_flag_q   <= irq_flag_d;
      ack_n_prev_q <= s_ack_n;
      epp_q        <= epp_d;
      epp_sel_q    <= epp_sel_d;
    end
  end

  always @(posedge mclk) begin
    if (!rst_n) begin
      io_rdata <= 8'h00;
    end else begin
      io_rdata <= rdata_d;
    end
  end

  // pins come straight from flops so decode changes never glitch them
  always @(posedge mclk) begin
    if (!rst_n) begin
      parallel_data_lines_out <= 8'h00;
      parallel_data_lines_oe  <= 1'b0;
      strobe_n                <= 1'b1;
      autofeed_n              <= 1'b1;
      init_n                  <= 1'b0;
      select_in_n             <= 1'b1;
      port_irq                <= 1'b0;
    end else begin
      parallel_data_lines_out <= pd_out_d;
      parallel_data_lines_oe  <= pd_oe_d;
      strobe_n                <= strobe_n_d;
      autofeed_n              <= autofeed_n_d;
      init_n                  <= init_n_d;
      select_in_n             <= select_in_n_d;
      port_irq                <= port_irq_d;
    end
  end
endmodule // ppr_port

// File: verif/ppr_checker.sv
`timescale 1ns/1ps
module ppr_checker (
  // host side and pins
  input wire       mclk, rst_n, io_rd, io_wr, ack_n, port_irq,
  input wire       strobe_n, autofeed_n, init_n, select_in_n, parallel_data_lines_oe,
  input wire [2:0] port_mode, io_addr,
  input wire [7:0] io_wdata, io_rdata, parallel_data_lines_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire       cw = io_wr && io_addr == 3'h2;
  wire [7:0] w = io_wdata;
  property p_st; cw |-> ##2 strobe_n != $past(w[0], 2); endproperty
  a_st: assert property (p_st) else $error("strobe");
  property p_af; cw |-> ##2 autofeed_n != $past(w[1], 2); endproperty
  a_af: assert property (p_af) else $error("autofeed");
  property p_in; cw |-> ##2 init_n == $past(w[2], 2); endproperty
  a_in: assert property (p_in) else $error("init");
  property p_si; cw |-> ##2 select_in_n != $past(w[3], 2); endproperty
  a_si: assert property (p_si) else $error("select");
  property p_dr; cw && port_mode == 3'h1 |-> ##2 parallel_data_lines_oe != $past(w[5], 2); endproperty
  a_dr: assert property (p_dr) else $error("direction");
  // sync plus output flop settle well inside 8 cycles
  property p_iq; ack_n [*8] |-> !port_irq; endproperty
  a_iq: assert property (p_iq) else $error("irq");
  property p_dt; io_wr && io_addr == 3'h0 && port_mode == 3'h0 |-> ##2 parallel_data_lines_out == $past(w, 2); endproperty
  a_dt: assert property (p_dt) else $error("data");
  property p_rs; io_rd && io_addr == 3'h2 |=> io_rdata[7:6] == 2'h0; endproperty
  a_rs: assert property (p_rs) else $error("reserved");
  c_iq: cover property (port_irq);
  c_rv: cover property (!parallel_data_lines_oe);
  c_st: cover property (io_rd && io_addr == 3'h1);
endmodule // ppr_checker
bind ppr_port ppr_checker i_ppr_checker (.*);

// File: verif/ppr_printer.sv
`timescale 1ns/1ps
module ppr_printer #(
  parameter DLY = 3
) (
  // pins
  input  wire mclk, strobe_n,
  output reg  busy = 1'b0, ack_n = 1'b1
);
  reg [4:0] n_q = 5'h0;
  // ack is a 12-cycle pulse DLY cycles after strobe releases
  always @(posedge mclk) begin
    busy <= !strobe_n || (n_q != 5'h0 && n_q < DLY + 12);
    ack_n <= !(n_q > DLY && n_q <= DLY + 12);
    n_q <= !strobe_n ? 5'h1 : (n_q == 5'h0 || n_q == DLY + 12) ? 5'h0 : n_q + 5'h1;
  end
endmodule // ppr_printer

// File: verif/tb_ppr_port.sv
`timescale 1ns/1ps
module tb_ppr_port;
  reg        mclk = 1'b0, rst_n = 1'b0, io_rd = 1'b0, io_wr = 1'b0;
  reg        paper_error = 1'b1, select = 1'b1, fault_n = 1'b0;
  reg  [2:0] port_mode = 3'h0, io_addr = 3'h0;
  reg  [9:0] port_base = 10'h378;
  reg  [7:0] io_wdata = 8'h00, d;
  wire [7:0] io_rdata, pd;
  wire       parallel_data_lines_oe, strobe_n, autofeed_n, init_n, select_in_n, busy, ack_n, port_irq;
  // reverse traffic: peripheral drives 3c only while the port has let go
  wire [7:0] parallel_data_lines_in = parallel_data_lines_oe ? pd : 8'h3c;
  integer    miscompares = 0, samples_checked = 0, i;
  ppr_port i_ppr_port (.parallel_data_lines_out(pd), .*);
  ppr_printer i_ppr_printer (.*);
  initial forever #10 mclk = ~mclk;
  task chk(input [15:0] n, input [7:0] g, e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task wr(input [2:0] a, input [7:0] v);
    @(posedge mclk) #1 io_addr = a;
    io_wdata = v;
    io_wr = 1'b1;
    @(posedge mclk) #1 io_wr = 1'b0;
    repeat (2) @(posedge mclk) #1;
  endtask
  task rd(input [2:0] a);
    @(posedge mclk) #1 io_addr = a;
    io_rd = 1'b1;
    @(posedge mclk) #1 io_rd = 1'b0;
    d = io_rdata;
  endtask
  task t_std;
    wr(3'h2, 8'hff);
    rd(3'h2);
    chk("cr", d & 8'hdf, 8'h1f);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'ha5);
    repeat (30) @(posedge mclk) #1;
    rd(3'h1);
    chk("s1", d, 8'hf4);
  endtask
  task t_bidir;
    port_mode = 3'h1;
    fault_n = 1'b1;
    wr(3'h2, 8'h11);
    wr(3'h2, 8'h10);
    for (i = 0; i < 60 && port_irq !== 1'b1; i = i + 1) @(posedge mclk) #1;
    chk("iq", {7'h0, port_irq}, 8'h01);
    if (port_irq !== 1'b1) test_done;
    rd(3'h1);
    chk("s2", d, 8'h38);
    rd(3'h1);
    chk("s4", d & 8'h04, 8'h04);
    wr(3'h2, 8'h20);
    wr(3'h0, 8'h66);
    rd(3'h0);
    chk("rv", d, 8'h3c);
    wr(3'h2, 8'h00);
    rd(3'h0);
    chk("kp", d, 8'ha5);
  endtask
  task t_epp;
    port_mode = 3'h4;
    wr(3'h2, 8'h00);
    rd(3'h1);
    chk("s3", d & 8'h07, 8'h04);
    for (i = 3; i < 8; i = i + 1) begin
      wr(i[2:0], 8'h50 + i[7:0]);
      chk("ep", pd, 8'h50 + i[7:0]);
    end
    port_base = 10'h3bc;
    wr(3'h3, 8'hc3);
    chk("bc", pd, 8'ha5);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    t_std;
    t_bidir;
    t_epp;
    test_done;
  end
endmodule // tb_ppr_port
